// ### common/prl_defines.vh
`ifndef PRL_DEFINES_VH
`define PRL_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PRL_OFS_INGRESS_RATE_P32 12'h08E
`define PRL_OFS_EGRESS_RATE_P10 12'h090
`define PRL_OFS_EGRESS_RATE_P32 12'h092
`define PRL_OFS_CABLE_DIAG 12'h094
`define PRL_OFS_PHY_CONTROL 12'h0A0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PRL_RATE_HI_MSB 14
`define PRL_RATE_HI_LSB 8
`define PRL_RATE_LO_MSB 6
`define PRL_RATE_LO_LSB 0
`define PRL_RSVD_HI_BIT 15
`define PRL_MID_BIT 7
`define PRL_NEAR_SHORT_BIT 15
`define PRL_RESULT_MSB 14
`define PRL_RESULT_LSB 13
`define PRL_TEST_START_BIT 12
`define PRL_FORCE_LINK_BIT 11
`define PRL_DIAG_RSVD_BIT 10
`define PRL_LOOPBACK_BIT 9
`define PRL_FAULT_MSB 8
`define PRL_FAULT_LSB 0
`define PRL_PHY_FORCE_LINK_BIT 3
`define PRL_PHY_LOOPBACK_BIT 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PRL_RATE_RST 7'h00
`define PRL_BIT_RST 1'h0
`define PRL_DIAG_RSVD_RST 1'h1
`define PRL_RESULT_RST 2'h0
`define PRL_ING_LIM_RST 2'h0
`define PRL_EGR_LIM_RST 4'h0
`define PRL_FAULT_RST 9'h000
`define PRL_DATA_ZERO 16'h0000

`endif

// ### rtl/prl_port_regs.v
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "prl_defines.vh"

module prl_port_regs
#(
    parameter ADDR_W = 12,
    parameter RATE_W = 7
)
(
    input wire I_CLOCK,
    input wire I_RSTN,
    input wire [ADDR_W-1:0] I_ADDR,
    input wire [15:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [15:0] O_RDATA,
    output reg [RATE_W-1:0] O_INGRESS_RATE_P2,
    output reg [RATE_W-1:0] O_INGRESS_RATE_P3,
    output reg [RATE_W-1:0] O_EGRESS_RATE_P0,
    output reg [RATE_W-1:0] O_EGRESS_RATE_P1,
    output reg [RATE_W-1:0] O_EGRESS_RATE_P2,
    output reg [RATE_W-1:0] O_EGRESS_RATE_P3,
    output reg O_EGRESS_LIMIT_EN,
    output reg [1:0] O_INGRESS_LIMITED_P32,
    output reg [3:0] O_EGRESS_LIMITED,
    output reg O_FORCE_LINK,
    output reg O_REMOTE_LOOPBACK,
    output reg O_CABLE_TEST_RUN,
    input wire I_CABLE_TEST_DONE,
    input wire I_NEAR_SHORT,
    input wire [1:0] I_CABLE_TEST_RESULT,
    input wire [8:0] I_FAULT_DISTANCE_COUNT
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function hit;
        input [ADDR_W-1:0] addr;
        input [11:0] ofs;
        begin
            hit = (addr == ofs[ADDR_W-1:0]);
        end
    endfunction

    // zero code is full line rate at either speed
    function limited;
        input [RATE_W-1:0] code;
        begin
            limited = (code != {RATE_W{1'h0}});
        end
    endfunction

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    reg ing_rsvd_hi_reg;
    reg ing_rsvd_mid_reg;
    reg eg0_rsvd_hi_reg;
    reg eg1_rsvd_hi_reg;
    reg eg1_rsvd_mid_reg;
    reg diag_rsvd_reg;
    reg near_short_reg;
    reg [1:0] cable_test_result_reg;
    reg [8:0] fault_distance_count_reg;
    reg [15:0] rdata_next;
    reg [RATE_W-1:0] ing_rate_p3_next;
    reg [RATE_W-1:0] ing_rate_p2_next;
    reg [RATE_W-1:0] eg_rate_p1_next;
    reg [RATE_W-1:0] eg_rate_p0_next;
    reg [RATE_W-1:0] eg_rate_p3_next;
    reg [RATE_W-1:0] eg_rate_p2_next;
    reg egress_limit_en_next;
    reg ing_rsvd_hi_next;
    reg ing_rsvd_mid_next;
    reg eg0_rsvd_hi_next;
    reg eg1_rsvd_hi_next;
    reg eg1_rsvd_mid_next;
    reg [1:0] ing_limited_next;
    reg [3:0] egr_limited_next;
    reg force_link_next;
    reg remote_loopback_next;
    reg diag_rsvd_next;
    reg cable_test_run_next;
    reg near_short_next;
    reg [1:0] cable_test_result_next;
    reg [8:0] fault_distance_count_next;

    wire wr_ing = I_WR & hit(I_ADDR, `PRL_OFS_INGRESS_RATE_P32);
    wire wr_eg0 = I_WR & hit(I_ADDR, `PRL_OFS_EGRESS_RATE_P10);
    wire wr_eg1 = I_WR & hit(I_ADDR, `PRL_OFS_EGRESS_RATE_P32);
    wire wr_diag = I_WR & hit(I_ADDR, `PRL_OFS_CABLE_DIAG);
    wire wr_phy = I_WR & hit(I_ADDR, `PRL_OFS_PHY_CONTROL);
    wire test_start = wr_diag & I_WDATA[`PRL_TEST_START_BIT];
    wire test_done = O_CABLE_TEST_RUN & I_CABLE_TEST_DONE;

    // ------------------------------------------------------------------
    // ingress rate register, priorities 3 and 2
    // ------------------------------------------------------------------
    // reserved bits are plain storage so software can round-trip a word
    always @*
    begin
        ing_rate_p3_next = O_INGRESS_RATE_P3;
        ing_rate_p2_next = O_INGRESS_RATE_P2;
        ing_rsvd_hi_next = ing_rsvd_hi_reg;
        ing_rsvd_mid_next = ing_rsvd_mid_reg;
        if (wr_ing)
        begin
            ing_rate_p3_next = I_WDATA[`PRL_RATE_HI_MSB:`PRL_RATE_HI_LSB];
            ing_rate_p2_next = I_WDATA[`PRL_RATE_LO_MSB:`PRL_RATE_LO_LSB];
            ing_rsvd_hi_next = I_WDATA[`PRL_RSVD_HI_BIT];
            ing_rsvd_mid_next = I_WDATA[`PRL_MID_BIT];
        end
    end

    always @(posedge I_CLOCK)
    begin
        if (!I_RSTN)
        begin
            O_INGRESS_RATE_P3 <= `PRL_RATE_RST;
            O_INGRESS_RATE_P2 <= `PRL_RATE_RST;
            ing_rsvd_hi_reg <= `PRL_BIT_RST;
            ing_rsvd_mid_reg <= `PRL_BIT_RST;
        end
        else
        begin
            O_INGRESS_RATE_P3 <= ing_rate_p3_next;
            O_INGRESS_RATE_P2 <= ing_rate_p2_next;
            ing_rsvd_hi_reg <= ing_rsvd_hi_next;
            ing_rsvd_mid_reg <= ing_rsvd_mid_next;
        end
    end

    // ------------------------------------------------------------------
    // egress rate register, priorities 1 and 0 with global enable
    // ------------------------------------------------------------------
    always @*
    begin
        eg_rate_p1_next = O_EGRESS_RATE_P1;
        eg_rate_p0_next = O_EGRESS_RATE_P0;
        egress_limit_en_next = O_EGRESS_LIMIT_EN;
        eg0_rsvd_hi_next = eg0_rsvd_hi_reg;
        if (wr_eg0)
        begin
            eg_rate_p1_next = I_WDATA[`PRL_RATE_HI_MSB:`PRL_RATE_HI_LSB];
            eg_rate_p0_next = I_WDATA[`PRL_RATE_LO_MSB:`PRL_RATE_LO_LSB];
            egress_limit_en_next = I_WDATA[`PRL_MID_BIT];
            eg0_rsvd_hi_next = I_WDATA[`PRL_RSVD_HI_BIT];
        end
    end

    always @(posedge I_CLOCK)
    begin
        if (!I_RSTN)
        begin
            O_EGRESS_RATE_P1 <= `PRL_RATE_RST;
            O_EGRESS_RATE_P0 <= `PRL_RATE_RST;
            O_EGRESS_LIMIT_EN <= `PRL_BIT_RST;
            eg0_rsvd_hi_reg <= `PRL_BIT_RST;
        end
        else
        begin
            O_EGRESS_RATE_P1 <= eg_rate_p1_next;
            O_EGRESS_RATE_P0 <= eg_rate_p0_next;
            O_EGRESS_LIMIT_EN <= egress_limit_en_next;
            eg0_rsvd_hi_reg <= eg0_rsvd_hi_next;
        end
    end

    // ------------------------------------------------------------------
    // egress rate register, priorities 3 and 2
    // ------------------------------------------------------------------
    always @*
    begin
        eg_rate_p3_next = O_EGRESS_RATE_P3;
        eg_rate_p2_next = O_EGRESS_RATE_P2;
        eg1_rsvd_hi_next = eg1_rsvd_hi_reg;
        eg1_rsvd_mid_next = eg1_rsvd_mid_reg;
        if (wr_eg1)
        begin
            eg_rate_p3_next = I_WDATA[`PRL_RATE_HI_MSB:`PRL_RATE_HI_LSB];
            eg_rate_p2_next = I_WDATA[`PRL_RATE_LO_MSB:`PRL_RATE_LO_LSB];
            eg1_rsvd_hi_next = I_WDATA[`PRL_RSVD_HI_BIT];
            eg1_rsvd_mid_next = I_WDATA[`PRL_MID_BIT];
        end
    end

    always @(posedge I_CLOCK)
    begin
        if (!I_RSTN)
        begin
            O_EGRESS_RATE_P3 <= `PRL_RATE_RST;
            O_EGRESS_RATE_P2 <= `PRL_RATE_RST;
            eg1_rsvd_hi_reg <= `PRL_BIT_RST;
            eg1_rsvd_mid_reg <= `PRL_BIT_RST;
        end
        else
        begin
            O_EGRESS_RATE_P3 <= eg_rate_p3_next;
            O_EGRESS_RATE_P2 <= eg_rate_p2_next;
            eg1_rsvd_hi_reg <= eg1_rsvd_hi_next;
            eg1_rsvd_mid_reg <= eg1_rsvd_mid_next;
        end
    end

    // ------------------------------------------------------------------
    // limiter qualifiers, registered so they track the codes one cycle late
    // ------------------------------------------------------------------
    always @*
    begin
        ing_limited_next = {limited(O_INGRESS_RATE_P3), limited(O_INGRESS_RATE_P2)};
        // egress needs the global enable as well as a nonzero code
        egr_limited_next = {4{O_EGRESS_LIMIT_EN}} &
            {limited(O_EGRESS_RATE_P3), limited(O_EGRESS_RATE_P2),
             limited(O_EGRESS_RATE_P1), limited(O_EGRESS_RATE_P0)};
    end

    always @(posedge I_CLOCK)
    begin
        if (!I_RSTN)
        begin
            O_INGRESS_LIMITED_P32 <= `PRL_ING_LIM_RST;
            O_EGRESS_LIMITED <= `PRL_EGR_LIM_RST;
        end
        else
        begin
            O_INGRESS_LIMITED_P32 <= ing_limited_next;
            O_EGRESS_LIMITED <= egr_limited_next;
        end
    end

    // ------------------------------------------------------------------
    // phy aliases and reserved diagnostic bit
    // ------------------------------------------------------------------
    always @*
    begin
        force_link_next = O_FORCE_LINK;
        remote_loopback_next = O_REMOTE_LOOPBACK;
        diag_rsvd_next = diag_rsvd_reg;
        // force link and loopback: one storage bit each, reachable from two addresses
        if (wr_diag)
        begin
            force_link_next = I_WDATA[`PRL_FORCE_LINK_BIT];
            remote_loopback_next = I_WDATA[`PRL_LOOPBACK_BIT];
            diag_rsvd_next = I_WDATA[`PRL_DIAG_RSVD_BIT];
        end
        else if (wr_phy)
        begin
            force_link_next = I_WDATA[`PRL_PHY_FORCE_LINK_BIT];
            remote_loopback_next = I_WDATA[`PRL_PHY_LOOPBACK_BIT];
        end
    end

    always @(posedge I_CLOCK)
    begin
        if (!I_RSTN)
        begin
            O_FORCE_LINK <= `PRL_BIT_RST;
            O_REMOTE_LOOPBACK <= `PRL_BIT_RST;
            diag_rsvd_reg <= `PRL_DIAG_RSVD_RST;
        end
        else
        begin
            O_FORCE_LINK <= force_link_next;
            O_REMOTE_LOOPBACK <= remote_loopback_next;
            diag_rsvd_reg <= diag_rsvd_next;
        end
    end

    // ------------------------------------------------------------------
    // cable test start bit and captured status
    // ------------------------------------------------------------------
    always @*
    begin
        cable_test_run_next = O_CABLE_TEST_RUN;
        near_short_next = near_short_reg;
        cable_test_result_next = cable_test_result_reg;
        fault_distance_count_next = fault_distance_count_reg;
        // a fresh start write beats a done in the same cycle; writing
        // zero cannot abort a running test
        if (test_start)
            cable_test_run_next = 1'h1;
        else if (test_done)
            cable_test_run_next = 1'h0;
        // status captured as the test ends, so it is valid once start reads 0;
        // a done while idle is a stray pulse and leaves the status alone
        if (test_done)
        begin
            near_short_next = I_NEAR_SHORT;
            cable_test_result_next = I_CABLE_TEST_RESULT;
            fault_distance_count_next = I_FAULT_DISTANCE_COUNT;
        end
    end

    always @(posedge I_CLOCK)
    begin
        if (!I_RSTN)
        begin
            O_CABLE_TEST_RUN <= `PRL_BIT_RST;
            near_short_reg <= `PRL_BIT_RST;
            cable_test_result_reg <= `PRL_RESULT_RST;
            fault_distance_count_reg <= `PRL_FAULT_RST;
        end
        else
        begin
            O_CABLE_TEST_RUN <= cable_test_run_next;
            near_short_reg <= near_short_next;
            cable_test_result_reg <= cable_test_result_next;
            fault_distance_count_reg <= fault_distance_count_next;
        end
    end

    // ------------------------------------------------------------------
    // read path, data valid the cycle after the strobe only
    // ------------------------------------------------------------------
    always @*
    begin
        rdata_next = `PRL_DATA_ZERO;
        if (I_RD)
        begin
            if (hit(I_ADDR, `PRL_OFS_INGRESS_RATE_P32))
            begin
                rdata_next[`PRL_RSVD_HI_BIT] = ing_rsvd_hi_reg;
                rdata_next[`PRL_RATE_HI_MSB:`PRL_RATE_HI_LSB] = O_INGRESS_RATE_P3;
                rdata_next[`PRL_MID_BIT] = ing_rsvd_mid_reg;
                rdata_next[`PRL_RATE_LO_MSB:`PRL_RATE_LO_LSB] = O_INGRESS_RATE_P2;
            end
            else if (hit(I_ADDR, `PRL_OFS_EGRESS_RATE_P10))
            begin
                rdata_next[`PRL_RSVD_HI_BIT] = eg0_rsvd_hi_reg;
                rdata_next[`PRL_RATE_HI_MSB:`PRL_RATE_HI_LSB] = O_EGRESS_RATE_P1;
                rdata_next[`PRL_MID_BIT] = O_EGRESS_LIMIT_EN;
                rdata_next[`PRL_RATE_LO_MSB:`PRL_RATE_LO_LSB] = O_EGRESS_RATE_P0;
            end
            else if (hit(I_ADDR, `PRL_OFS_EGRESS_RATE_P32))
            begin
                rdata_next[`PRL_RSVD_HI_BIT] = eg1_rsvd_hi_reg;
                rdata_next[`PRL_RATE_HI_MSB:`PRL_RATE_HI_LSB] = O_EGRESS_RATE_P3;
                rdata_next[`PRL_MID_BIT] = eg1_rsvd_mid_reg;
                rdata_next[`PRL_RATE_LO_MSB:`PRL_RATE_LO_LSB] = O_EGRESS_RATE_P2;
            end
            else if (hit(I_ADDR, `PRL_OFS_CABLE_DIAG))
            begin
                rdata_next[`PRL_NEAR_SHORT_BIT] = near_short_reg;
                rdata_next[`PRL_RESULT_MSB:`PRL_RESULT_LSB] = cable_test_result_reg;
                rdata_next[`PRL_TEST_START_BIT] = O_CABLE_TEST_RUN;
                rdata_next[`PRL_FORCE_LINK_BIT] = O_FORCE_LINK;
                rdata_next[`PRL_DIAG_RSVD_BIT] = diag_rsvd_reg;
                rdata_next[`PRL_LOOPBACK_BIT] = O_REMOTE_LOOPBACK;
                rdata_next[`PRL_FAULT_MSB:`PRL_FAULT_LSB] = fault_distance_count_reg;
            end
            else if (hit(I_ADDR, `PRL_OFS_PHY_CONTROL))
            begin
                rdata_next[`PRL_PHY_FORCE_LINK_BIT] = O_FORCE_LINK;
                rdata_next[`PRL_PHY_LOOPBACK_BIT] = O_REMOTE_LOOPBACK;
            end
        end
    end

    always @(posedge I_CLOCK)
    begin
        if (!I_RSTN)
            O_RDATA <= `PRL_DATA_ZERO;
        else
            O_RDATA <= rdata_next;
    end

endmodule

// ### sim/prl_port_regs_chk.sv
`timescale 1ns/1ps
module prl_port_regs_chk
#(
    parameter ADDR_W = 12,
    parameter RATE_W = 7
)
(
    input wire I_CLOCK,
    input wire I_RSTN,
    input wire [ADDR_W-1:0] I_ADDR,
    input wire [15:0] I_WDATA,
    input wire I_WR,
    input wire [RATE_W-1:0] O_INGRESS_RATE_P2,
    input wire [RATE_W-1:0] O_INGRESS_RATE_P3,
    input wire [RATE_W-1:0] O_EGRESS_RATE_P0,
    input wire [RATE_W-1:0] O_EGRESS_RATE_P1,
    input wire [RATE_W-1:0] O_EGRESS_RATE_P3,
    input wire O_EGRESS_LIMIT_EN,
    input wire [1:0] O_INGRESS_LIMITED_P32,
    input wire [3:0] O_EGRESS_LIMITED,
    input wire O_FORCE_LINK,
    input wire O_REMOTE_LOOPBACK,
    input wire O_CABLE_TEST_RUN,
    input wire I_CABLE_TEST_DONE
);
    wire wr_ing = I_WR && I_ADDR == 12'h08E;
    wire wr_egr = I_WR && I_ADDR == 12'h090;
    wire wr_phy = I_WR && I_ADDR == 12'h0A0;
    wire start = I_WR && I_ADDR == 12'h094 && I_WDATA[12];
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RSTN);

    ing_p3_wr_a: assert property (wr_ing |=> O_INGRESS_RATE_P3 == $past(I_WDATA[14:8]))
        else $error("ingress p3 code not stored");
    egr_p1_wr_a: assert property (wr_egr |=> O_EGRESS_RATE_P1 == $past(I_WDATA[14:8]))
        else $error("egress p1 code not stored");
    limit_en_wr_a: assert property (wr_egr |=> O_EGRESS_LIMIT_EN == $past(I_WDATA[7]))
        else $error("egress enable not stored");
    ing_limited_a: assert property (O_INGRESS_LIMITED_P32 == {$past(O_INGRESS_RATE_P3) != 0,
        $past(O_INGRESS_RATE_P2) != 0}) else $error("ingress limited flags wrong");
    egr_limited_a: assert property ((O_EGRESS_LIMITED[0] == ($past(O_EGRESS_LIMIT_EN) &&
        $past(O_EGRESS_RATE_P0) != 0)) && (O_EGRESS_LIMITED[3] == ($past(O_EGRESS_LIMIT_EN) &&
        $past(O_EGRESS_RATE_P3) != 0))) else $error("egress limited flags wrong");
    test_start_a: assert property (start |=> O_CABLE_TEST_RUN)
        else $error("test did not start");
    test_clear_a: assert property (O_CABLE_TEST_RUN && I_CABLE_TEST_DONE && !start |=> !O_CABLE_TEST_RUN)
        else $error("test bit not self cleared");
    test_hold_a: assert property (O_CABLE_TEST_RUN && !I_CABLE_TEST_DONE |=> O_CABLE_TEST_RUN)
        else $error("test bit dropped early");
    force_alias_a: assert property (wr_phy |=> O_FORCE_LINK == $past(I_WDATA[3]))
        else $error("force link alias broken");
    loop_alias_a: assert property (wr_phy |=> O_REMOTE_LOOPBACK == $past(I_WDATA[1]))
        else $error("loopback alias broken");
endmodule

// ### sim/prl_port_regs_tb.sv
`timescale 1ns/1ps
module prl_port_regs_tb;
    reg clock = 1'h0;
    reg rst_n = 1'h0;
    reg [11:0] addr = 12'h000;
    reg [15:0] wdata = 16'h0000;
    reg wr = 1'h0, rd = 1'h0, done = 1'h0, near = 1'h0;
    reg [1:0] result = 2'h0;
    reg [8:0] fault = 9'h000;
    wire [15:0] rdata;
    wire [6:0] ing_p2, ing_p3, egr_p0, egr_p1, egr_p2, egr_p3;
    wire [1:0] ing_lim;
    wire [3:0] egr_lim;
    wire lim_en, force_link, loopback, run;
    integer failures = 0;
    integer total_checks = 0;
    integer k;

    prl_port_regs prl_port_regs_inst (.I_CLOCK(clock), .I_RSTN(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_INGRESS_RATE_P2(ing_p2), .O_INGRESS_RATE_P3(ing_p3),
        .O_EGRESS_RATE_P0(egr_p0), .O_EGRESS_RATE_P1(egr_p1), .O_EGRESS_RATE_P2(egr_p2),
        .O_EGRESS_RATE_P3(egr_p3), .O_EGRESS_LIMIT_EN(lim_en), .O_INGRESS_LIMITED_P32(ing_lim),
        .O_EGRESS_LIMITED(egr_lim), .O_FORCE_LINK(force_link), .O_REMOTE_LOOPBACK(loopback),
        .O_CABLE_TEST_RUN(run), .I_CABLE_TEST_DONE(done), .I_NEAR_SHORT(near),
        .I_CABLE_TEST_RESULT(result), .I_FAULT_DISTANCE_COUNT(fault));

    initial
    begin
        forever #12.5 clock = ~clock;
    end

    task chk(input string what, input [15:0] seen, input [15:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    end
    endtask

    // settle 1 ns past the edge so registered outputs are sampled stable
    task bus_wr(input [11:0] a, input [15:0] d);
    begin
        @(posedge clock);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'h0;
        #1;
    end
    endtask

    task bus_rd(input [11:0] a, input [15:0] exp, input string what);
    begin
        @(posedge clock);
        rd <= 1'h1;
        addr <= a;
        @(posedge clock);
        rd <= 1'h0;
        #1;
        chk(what, rdata, exp);
    end
    endtask

    task test_pulse(input n, input [1:0] r, input [8:0] f);
    begin
        @(posedge clock);
        done <= 1'h1;
        near <= n;
        result <= r;
        fault <= f;
        @(posedge clock);
        done <= 1'h0;
        #1;
    end
    endtask

    task t_reset;
    begin
        bus_rd(12'h08E, 16'h0000, "ingress reset");
        bus_rd(12'h090, 16'h0000, "egress0 reset");
        bus_rd(12'h092, 16'h0000, "egress1 reset");
        bus_rd(12'h094, 16'h0400, "diag reset");
        chk("limited reset", {egr_lim, ing_lim}, 16'h0000);
        $display("test reset done");
    end
    endtask

    task t_rates;
    begin
        bus_wr(12'h08E, 16'hD5AA);
        chk("ingress codes", {ing_p3, ing_p2}, {7'h55, 7'h2A});
        bus_rd(12'h08E, 16'hD5AA, "ingress read");
        chk("ingress limited", ing_lim, 16'h0003);
        bus_wr(12'h090, 16'h0281);
        chk("egress p1 p0", {lim_en, egr_p1, egr_p0}, {1'h1, 7'h02, 7'h01});
        bus_wr(12'h092, 16'hFF80);
        chk("egress p3 p2", {egr_p3, egr_p2}, {7'h7F, 7'h00});
        bus_rd(12'h092, 16'hFF80, "egress1 read");
        chk("egress limited", egr_lim, 16'h000B);
        bus_wr(12'h090, 16'h0201);
        bus_rd(12'h090, 16'h0201, "egress0 read");
        chk("egress disabled", egr_lim, 16'h0000);
        bus_wr(12'h08F, 16'hFFFF);
        bus_rd(12'h08F, 16'h0000, "unmapped read");
        bus_wr(12'h08E, 16'h0000);
        bus_rd(12'h08E, 16'h0000, "ingress cleared");
        chk("zero code unlimited", ing_lim, 16'h0000);
        $display("test rates done");
    end
    endtask

    task t_diag;
    begin
        bus_wr(12'h094, 16'hFFFF);
        chk("diag controls", {run, force_link, loopback}, 16'h0007);
        bus_rd(12'h094, 16'h1E00, "diag read");
        bus_rd(12'h0A0, 16'h000A, "phy alias");
        bus_wr(12'h0A0, 16'h0000);
        bus_rd(12'h094, 16'h1400, "alias cleared");
        bus_wr(12'h094, 16'h0400);
        chk("start kept", run, 16'h0001);
        for (k = 0; k < 4; k = k + 1)
        begin
            test_pulse(k[0], k[1:0], {k[1:0], 7'h25});
            chk("test done", run, 16'h0000);
            bus_rd(12'h094, {k[0], k[1:0], 4'h2, k[1:0], 7'h25}, "status");
            // restart with the reserved bit kept at one, as the next status read expects
            bus_wr(12'h094, 16'h1400);
        end
        test_pulse(1'h0, 2'h0, 9'h000);
        test_pulse(1'h1, 2'h3, 9'h1FF);
        bus_rd(12'h094, 16'h0400, "idle pulse ignored");
        $display("test diag done");
    end
    endtask

    task tally_and_finish;
    begin
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'h1;
        t_reset;
        t_rates;
        t_diag;
        tally_and_finish;
    end
endmodule

bind prl_port_regs prl_port_regs_chk #(.ADDR_W(ADDR_W), .RATE_W(RATE_W)) prl_port_regs_chk_inst (
    .I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .O_INGRESS_RATE_P2(O_INGRESS_RATE_P2), .O_INGRESS_RATE_P3(O_INGRESS_RATE_P3),
    .O_EGRESS_RATE_P0(O_EGRESS_RATE_P0), .O_EGRESS_RATE_P1(O_EGRESS_RATE_P1),
    .O_EGRESS_RATE_P3(O_EGRESS_RATE_P3), .O_EGRESS_LIMIT_EN(O_EGRESS_LIMIT_EN),
    .O_INGRESS_LIMITED_P32(O_INGRESS_LIMITED_P32), .O_EGRESS_LIMITED(O_EGRESS_LIMITED),
    .O_FORCE_LINK(O_FORCE_LINK), .O_REMOTE_LOOPBACK(O_REMOTE_LOOPBACK),
    .O_CABLE_TEST_RUN(O_CABLE_TEST_RUN), .I_CABLE_TEST_DONE(I_CABLE_TEST_DONE));
